// File: hw/rcl_pkg.sv
// Purpose: Shared constants and types for the radio config code loader
// Assumes: Codes arrive as a byte stream, fields packed MSB first
// Notes: Register map, field widths and record layouts live here
//
// Overview of operation
// (R1) Code: control, objects, elements, optional next offset
// (R2) Last-config flag set stops further fetching
// (R3) Extract job, version, library, author, date fields
// (R4) Object count, then object plus switch entries
// (R5) Element count, then that many element codes
// (R6) Object code: fixed set part, variable init
// (R7) Apply object size and access time
// (R8) One-byte init length, then immediate bytes
// (R9) Nonzero length fills object, zero leaves empty
// (R10) Element fields decoded in fixed order
// (R11) Dynamic flag: inactive after operation completes
// (R12) Two-bit port access type, four kinds
// (R13) Zero cost or time means none
// (R14) Bind operation code and port access types
// (R15) Configured element goes active, tells control unit
// (R16) Element exception code, four values
// (R17) Connectors join object ports to element ports
// (R18) Switch code: id, count, element/port entries; code reads no id field, uses the object index
// (R19) Object exception code, four values
// (R20) Configure all first, stop on any exception
// (R21) MSB first packing, fixed access encoding
// (R22) Truncation or overflow aborts, incorrect operation
package rcl_pkg;

// ==========================================================
// Register map
localparam logic [7:0] RCL_OFF_CTRL = 8'h00;
localparam logic [7:0] RCL_OFF_STATUS = 8'h04;
localparam logic [7:0] RCL_OFF_ID0 = 8'h08;
localparam logic [7:0] RCL_OFF_ID1 = 8'h0c;
localparam logic [7:0] RCL_OFF_NEXT = 8'h10;
localparam logic [7:0] RCL_OFF_COUNT = 8'h14;
localparam int RCL_CTRL_START = 0;
localparam int RCL_CTRL_ABORT = 1;

// ==========================================================
// Field widths in bits
localparam logic [5:0] RCL_W_FLAG = 6'h01;
localparam logic [5:0] RCL_W_BYTE = 6'h08;
localparam logic [5:0] RCL_W_HALF = 6'h10;
localparam logic [5:0] RCL_W_OPCODE = 6'h14;
localparam logic [5:0] RCL_W_PORTS = 6'h03;
localparam logic [5:0] RCL_W_ACC = 6'h02;
localparam logic [5:0] RCL_W_SWN = 6'h06;
localparam logic [5:0] RCL_W_SWENT = 6'h0c;
localparam logic [5:0] RCL_W_OFFSET = 6'h20;
localparam logic [5:0] RCL_W_NONE = 6'h00;

// ==========================================================
// Exception codes
localparam logic [1:0] RCL_EXC_NONE = 2'h0;
localparam logic [1:0] RCL_EXC_FLOW = 2'h1;
localparam logic [1:0] RCL_EXC_ARITH = 2'h2;
localparam logic [1:0] RCL_EXC_BADOP = 2'h3;
localparam logic [1:0] RCL_DOX_SIZE = 2'h1;
localparam logic [1:0] RCL_DOX_WRITES = 2'h2;
localparam logic [1:0] RCL_DOX_ERASE = 2'h3;

typedef enum logic [1:0] {
	RCL_ACC_READ = 2'h0,
	RCL_ACC_READ_ERASE = 2'h1,
	RCL_ACC_WRITE = 2'h2,
	RCL_ACC_READ_ERASE_WRITE = 2'h3
} rcl_access_t; // R12 R21

typedef struct packed {
	logic [7:0] obj_id;
	logic [15:0] size;
	logic [15:0] access_time;
	logic full;
} rcl_obj_cfg_t;

typedef struct packed {
	logic [7:0] obj_id;
	logic [7:0] index;
	logic [7:0] value;
} rcl_obj_init_t;

typedef struct packed {
	logic [7:0] obj_id;
	logic [7:0] element;
	logic [3:0] port;
} rcl_sw_conn_t;

typedef struct packed {
	logic [15:0] element_identifier;
	logic [19:0] opcode;
	logic dynamic;
	logic [2:0] port_count;
	logic [15:0] cost;
	logic [15:0] time_limit;
	logic no_cost;
	logic no_time;
	logic [13:0] access;
} rcl_pe_cfg_t;

endpackage

// File: hw/rcl_bit_reader.sv
// Purpose: Turns a byte stream into bit fields of chosen width
// Assumes: Width never exceeds 32 bits
// Notes: Holds at most 40 bits; oldest bit is the MSB of the field
`timescale 1ns/1ps
module rcl_bit_reader
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic clear_i,
	input wire logic in_valid_i,
	input wire logic [7:0] in_data_i,
	output logic in_ready_o,
	input wire logic take_i,
	input wire logic [5:0] width_i,
	output logic field_ok_o,
	output logic [31:0] field_o
);
	import rcl_pkg::*;

	logic [39:0] buf_r;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [39:0] buf_nxt;
	wire push = in_valid_i && in_ready_o;
	wire take = take_i && field_ok_o;
	wire [5:0] shift_amt = cnt_r - width_i;
	wire [39:0] shifted = buf_r >> shift_amt;
	wire [39:0] mask = (40'h1 << width_i) - 40'h1;
	wire [5:0] cnt_left = take ? shift_amt : cnt_r;

	// Byte room below 33 bits, so none is lost
	assign in_ready_o = (cnt_r <= 6'h20) && !clear_i;
	assign field_ok_o = (cnt_r >= width_i);
	assign field_o = shifted[31:0] & mask[31:0]; // R21
	assign buf_nxt = push ? {buf_r[31:0], in_data_i} : buf_r;
	assign cnt_nxt = push ? cnt_left + 6'h08 : cnt_left;

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			buf_r <= 40'h0;
			cnt_r <= 6'h00;
		end
		else
		begin
			buf_r <= clear_i ? 40'h0 : buf_nxt;
			cnt_r <= clear_i ? 6'h00 : cnt_nxt;
		end
	end
endmodule

// File: hw/rcl_loader.sv
// Purpose: Parses binary configuration codes and configures data path
// Assumes: AHB-Lite slave with zero wait states, single word transfers
// Notes: Object identifiers are the entry index within each code
`timescale 1ns/1ps
module rcl_loader
#(
	parameter int MAX_OBJ = 64,
	parameter int MAX_PE = 256
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic cfg_valid_i,
	input wire logic [7:0] cfg_data_i,
	input wire logic cfg_last_i,
	output logic cfg_ready_o,
	output rcl_pkg::rcl_obj_cfg_t obj_cfg_o,
	output logic obj_cfg_valid_o,
	output rcl_pkg::rcl_obj_init_t obj_init_o,
	output logic obj_init_valid_o,
	output rcl_pkg::rcl_sw_conn_t sw_conn_o,
	output logic sw_conn_valid_o,
	output rcl_pkg::rcl_pe_cfg_t pe_cfg_o,
	output logic pe_active_o,
	output logic code_end_o,
	output logic task_end_o,
	output logic exec_enable_o,
	output logic [1:0] pe_exc_o,
	output logic [1:0] obj_exc_o
);
	import rcl_pkg::*;

	typedef enum logic [4:0] {
		S_IDLE, S_LCF, S_NAF, S_JOB, S_IFV, S_LIB, S_IMPV, S_AUTH,
		S_DATE, S_OCNT, S_OSIZE, S_OACC, S_OLEN, S_OBYTE, S_SWN,
		S_SWENT, S_ECNT, S_EID, S_EOP, S_EDYN, S_EPN, S_ECOST,
		S_ETIME, S_EACC, S_NOFF, S_DONE, S_ERR
	} rcl_state_t;

	// ==========================================================
	// Field width per parse step
	function automatic logic [5:0] step_width(input rcl_state_t s);
		case (s)
			S_LCF, S_NAF, S_EDYN: step_width = RCL_W_FLAG;
			S_JOB, S_IFV, S_LIB, S_IMPV: step_width = RCL_W_BYTE;
			S_OCNT, S_OLEN, S_OBYTE: step_width = RCL_W_BYTE;
			S_AUTH, S_DATE, S_OSIZE, S_OACC: step_width = RCL_W_HALF;
			S_ECNT, S_EID, S_ECOST, S_ETIME: step_width = RCL_W_HALF;
			S_EOP: step_width = RCL_W_OPCODE;
			S_EPN: step_width = RCL_W_PORTS;
			S_EACC: step_width = RCL_W_ACC;
			S_SWN: step_width = RCL_W_SWN;
			S_SWENT: step_width = RCL_W_SWENT;
			S_NOFF: step_width = RCL_W_OFFSET;
			default: step_width = RCL_W_NONE;
		endcase
	endfunction

	rcl_state_t state_r;
	logic last_cfg_r;
	logic naf_r;
	logic src_end_r;
	logic [7:0] job_r, ifv_r, lib_r, impv_r;
	logic [15:0] auth_r, date_r;
	logic [31:0] next_off_r;
	logic next_seen_r;
	logic [15:0] codes_r, pe_total_r;
	logic [7:0] obj_cnt_r, obj_idx_r, len_r, byte_idx_r;
	logic [5:0] sw_n_r, sw_idx_r;
	logic [15:0] pe_cnt_r, pe_idx_r;
	logic [2:0] port_idx_r;
	logic [1:0] pe_exc_r, obj_exc_r;
	rcl_obj_cfg_t obj_r;
	rcl_pe_cfg_t pe_r;
	logic [31:0] field;
	logic field_ok;
	logic rd_ready;

	// ==========================================================
	// Bus slave
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	wire addr_phase = hsel_i && hready_i && htrans_i[1];
	wire [7:0] a_off = haddr_i[7:0];
	wire hit_ctrl = wr_pend_r && (wr_addr_r == RCL_OFF_CTRL);
	wire sw_start = hit_ctrl && hwdata_i[RCL_CTRL_START];
	wire sw_abort = hit_ctrl && hwdata_i[RCL_CTRL_ABORT];
	wire busy = (state_r != S_IDLE) && (state_r != S_DONE)
		&& (state_r != S_ERR);
	wire [31:0] status_word = {23'h0, next_seen_r, obj_exc_r,
		pe_exc_r, exec_enable_o, state_r == S_ERR,
		state_r == S_DONE, busy};
	logic [31:0] rd_word;

	always_comb
	begin
		rd_word = 32'h0;
		if (a_off == RCL_OFF_STATUS)
			rd_word = status_word;
		else if (a_off == RCL_OFF_ID0)
			rd_word = {job_r, ifv_r, lib_r, impv_r};
		else if (a_off == RCL_OFF_ID1)
			rd_word = {auth_r, date_r};
		else if (a_off == RCL_OFF_NEXT)
			rd_word = next_off_r;
		else if (a_off == RCL_OFF_COUNT)
			rd_word = {pe_total_r, codes_r};
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			{wr_pend_r, wr_addr_r} <= 9'h0;
			hrdata_o <= 32'h0;
		end
		else
		begin
			wr_pend_r <= addr_phase && hwrite_i;
			if (addr_phase)
				wr_addr_r <= a_off;
			if (addr_phase && !hwrite_i)
				hrdata_o <= rd_word;
		end
	end

	// ==========================================================
	// Field extraction
	wire [5:0] width = step_width(state_r);
	wire step = busy && field_ok && (width != RCL_W_NONE);
	wire starved = busy && !field_ok && src_end_r; // R22
	wire rd_clear = (sw_start && !busy) || sw_abort;

	assign cfg_ready_o = busy && rd_ready && !src_end_r; // R2

	rcl_bit_reader u_reader
	(
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.clear_i(rd_clear),
		.in_valid_i(cfg_valid_i && busy && !src_end_r),
		.in_data_i(cfg_data_i),
		.in_ready_o(rd_ready),
		.take_i(step),
		.width_i(width),
		.field_ok_o(field_ok),
		.field_o(field)
	);

	// ==========================================================
	// Decisions taken on the current field
	wire objs_over = ({24'h0, field[7:0]} > MAX_OBJ); // R22
	wire pes_over = ({16'h0, field[15:0]} > MAX_PE); // R22
	wire last_obj = (obj_idx_r + 8'h01 == obj_cnt_r);
	wire last_pe = (pe_idx_r + 16'h0001 == pe_cnt_r);
	wire last_port = (port_idx_r + 3'h1 == pe_r.port_count);
	wire last_ent = (sw_idx_r + 6'h01 == sw_n_r);
	wire last_byte = (byte_idx_r + 8'h01 == len_r);
	wire len_over = ({8'h0, field[7:0]} > obj_r.size); // R19
	wire [2:0] pn = field[2:0];

	rcl_state_t after_code;
	rcl_state_t after_obj;
	rcl_state_t after_pe;
	assign after_code = naf_r ? S_NOFF : (last_cfg_r ? S_DONE : S_LCF); // R1
	assign after_obj = last_obj ? S_ECNT : S_OSIZE;
	assign after_pe = last_pe ? after_code : S_EID;

	wire code_done = step && ((!naf_r && (((state_r == S_ETIME)
		&& (pe_r.port_count == 3'h0) && last_pe) || ((state_r == S_EACC)
		&& last_port && last_pe) || ((state_r == S_ECNT)
		&& (field[15:0] == 16'h0)))) || (state_r == S_NOFF));

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_r <= S_IDLE;
			src_end_r <= 1'b0;
		end
		else if (sw_abort)
			state_r <= S_IDLE;
		else if (sw_start && !busy)
		begin
			state_r <= S_LCF;
			src_end_r <= 1'b0;
		end
		else
		begin
			if (cfg_valid_i && cfg_ready_o && cfg_last_i)
				src_end_r <= 1'b1;
			if (starved)
				state_r <= S_ERR; // R22
			else if (step)
			begin
				case (state_r)
					S_LCF: state_r <= S_NAF;
					S_NAF: state_r <= S_JOB;
					S_JOB: state_r <= S_IFV; // R3
					S_IFV: state_r <= S_LIB;
					S_LIB: state_r <= S_IMPV;
					S_IMPV: state_r <= S_AUTH;
					S_AUTH: state_r <= S_DATE;
					S_DATE: state_r <= S_OCNT;
					S_OCNT:
					begin
						if (objs_over)
							state_r <= S_ERR;
						else if (field[7:0] == 8'h00)
							state_r <= S_ECNT;
						else
							state_r <= S_OSIZE; // R4
					end
					S_OSIZE: state_r <= S_OACC; // R6
					S_OACC:
					begin
						if (obj_r.size == 16'h0 || field[15:0] == 16'h0)
							state_r <= S_ERR; // R7
						else
							state_r <= S_OLEN;
					end
					S_OLEN:
					begin
						if (len_over)
							state_r <= S_ERR; // R19
						else if (field[7:0] == 8'h00)
							state_r <= S_SWN;
						else
							state_r <= S_OBYTE; // R8
					end
					S_OBYTE: state_r <= last_byte ? S_SWN : S_OBYTE;
					S_SWN: state_r <= (field[5:0] == 6'h00) ? after_obj
						: S_SWENT; // R18
					S_SWENT: state_r <= last_ent ? after_obj : S_SWENT;
					S_ECNT:
					begin
						if (pes_over)
							state_r <= S_ERR;
						else if (field[15:0] == 16'h0)
							state_r <= after_code;
						else
							state_r <= S_EID; // R5
					end
					S_EID: state_r <= S_EOP; // R10
					S_EOP: state_r <= S_EDYN;
					S_EDYN: state_r <= S_EPN;
					S_EPN: state_r <= S_ECOST;
					S_ECOST: state_r <= S_ETIME;
					S_ETIME: state_r <= (pe_r.port_count == 3'h0)
						? after_pe : S_EACC;
					S_EACC: state_r <= last_port ? after_pe : S_EACC;
					S_NOFF: state_r <= last_cfg_r ? S_DONE : S_LCF;
					default: state_r <= state_r;
				endcase
			end
		end
	end

	// ==========================================================
	// Captured fields and counters
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			{last_cfg_r, naf_r, next_seen_r} <= 3'h0;
			{job_r, ifv_r, lib_r, impv_r, auth_r, date_r} <= 64'h0;
			next_off_r <= 32'h0;
			{obj_cnt_r, obj_idx_r, len_r, byte_idx_r} <= 32'h0;
			{sw_n_r, sw_idx_r, pe_cnt_r, pe_idx_r} <= 44'h0;
			port_idx_r <= 3'h0;
			obj_r <= '0;
			pe_r <= '0;
		end
		else if (step)
		begin
			case (state_r)
				S_LCF: last_cfg_r <= field[0]; // R2
				S_NAF: naf_r <= field[0]; // R1
				S_JOB: job_r <= field[7:0]; // R3
				S_IFV: ifv_r <= field[7:0];
				S_LIB: lib_r <= field[7:0];
				S_IMPV: impv_r <= field[7:0];
				S_AUTH: auth_r <= field[15:0];
				S_DATE: date_r <= field[15:0];
				S_OCNT:
				begin
					obj_cnt_r <= field[7:0];
					obj_idx_r <= 8'h00;
					obj_r.obj_id <= 8'h00;
				end
				S_OSIZE: obj_r.size <= field[15:0]; // R7
				S_OACC: obj_r.access_time <= field[15:0];
				S_OLEN:
				begin
					len_r <= field[7:0];
					byte_idx_r <= 8'h00;
					obj_r.full <= (field[7:0] != 8'h00); // R9
				end
				S_OBYTE: byte_idx_r <= byte_idx_r + 8'h01;
				S_SWN:
				begin
					sw_n_r <= field[5:0];
					sw_idx_r <= 6'h00;
				end
				S_SWENT: sw_idx_r <= sw_idx_r + 6'h01;
				S_ECNT:
				begin
					pe_cnt_r <= field[15:0];
					pe_idx_r <= 16'h0;
				end
				S_EID:
				begin
					pe_r <= '0;
					pe_r.element_identifier <= field[15:0];
					port_idx_r <= 3'h0;
				end
				S_EOP: pe_r.opcode <= field[19:0]; // R14
				S_EDYN: pe_r.dynamic <= field[0]; // R11
				S_EPN: pe_r.port_count <= pn;
				S_ECOST:
				begin
					pe_r.cost <= field[15:0];
					pe_r.no_cost <= (field[15:0] == 16'h0); // R13
				end
				S_ETIME:
				begin
					pe_r.time_limit <= field[15:0];
					pe_r.no_time <= (field[15:0] == 16'h0); // R13
					if (pe_r.port_count == 3'h0)
						pe_idx_r <= pe_idx_r + 16'h0001;
				end
				S_EACC:
				begin
					pe_r.access[{port_idx_r, 1'b0} +: 2] <= field[1:0]; // R12
					port_idx_r <= port_idx_r + 3'h1;
					if (last_port)
						pe_idx_r <= pe_idx_r + 16'h0001;
				end
				S_NOFF:
				begin
					next_off_r <= field;
					next_seen_r <= 1'b1;
				end
			endcase
			if ((state_r == S_SWENT && last_ent) || (state_r == S_SWN
				&& field[5:0] == 6'h00))
			begin
				obj_idx_r <= obj_idx_r + 8'h01;
				obj_r.obj_id <= obj_idx_r + 8'h01;
			end
		end
		else if (sw_start && !busy)
			next_seen_r <= 1'b0;
	end

	// ==========================================================
	// Configuration outputs toward the data path and control unit
	wire obj_emit = step && (((state_r == S_OLEN) && (field[7:0]
		== 8'h00) && !len_over) || ((state_r == S_OBYTE)
		&& last_byte));
	wire pe_emit = step && (((state_r == S_ETIME)
		&& (pe_r.port_count == 3'h0)) || ((state_r == S_EACC)
		&& last_port));
	wire fail_now = starved || (step && (((state_r == S_OCNT)
		&& objs_over) || ((state_r == S_ECNT) && pes_over)
		|| ((state_r == S_OACC) && (obj_r.size == 16'h0
		|| field[15:0] == 16'h0))));

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			{obj_cfg_o, obj_init_o, sw_conn_o, pe_cfg_o} <= '0;
			{obj_cfg_valid_o, obj_init_valid_o, sw_conn_valid_o} <= 3'h0;
			{pe_active_o, code_end_o} <= 2'h0;
			{codes_r, pe_total_r} <= 32'h0;
			pe_exc_r <= RCL_EXC_NONE;
			obj_exc_r <= RCL_EXC_NONE;
		end
		else
		begin
			obj_cfg_valid_o <= obj_emit; // R9
			obj_init_valid_o <= step && (state_r == S_OBYTE);
			sw_conn_valid_o <= step && (state_r == S_SWENT); // R17
			pe_active_o <= pe_emit; // R15
			code_end_o <= code_done;
			if (obj_emit)
				obj_cfg_o <= obj_r; // R7
			if (obj_emit && state_r == S_OLEN)
				obj_cfg_o.full <= 1'b0; // R9
			if (step && state_r == S_OBYTE)
				obj_init_o <= {obj_r.obj_id, byte_idx_r, field[7:0]};
			if (step && state_r == S_SWENT)
				sw_conn_o <= {obj_r.obj_id, field[11:4], field[3:0]}; // R18
			if (pe_emit)
			begin
				pe_cfg_o <= pe_r; // R14
				if (state_r == S_EACC)
					pe_cfg_o.access[{port_idx_r, 1'b0} +: 2] <= field[1:0];
				else
				begin
					pe_cfg_o.time_limit <= field[15:0];
					pe_cfg_o.no_time <= (field[15:0] == 16'h0); // R13
				end
				pe_total_r <= pe_total_r + 16'h0001;
			end
			if (code_done)
				codes_r <= codes_r + 16'h0001;
			if (sw_start && !busy)
			begin
				codes_r <= 16'h0;
				pe_total_r <= 16'h0;
				pe_exc_r <= RCL_EXC_NONE;
				obj_exc_r <= RCL_EXC_NONE;
			end
			else if (step && state_r == S_OLEN && len_over)
				obj_exc_r <= RCL_DOX_SIZE; // R19
			else if (fail_now)
				pe_exc_r <= RCL_EXC_BADOP; // R16 R22
		end
	end

	// Execution waits until every element of the last code is set up
	assign task_end_o = (state_r == S_DONE); // R2
	assign exec_enable_o = (state_r == S_DONE) && (pe_exc_r
		== RCL_EXC_NONE) && (obj_exc_r == RCL_EXC_NONE); // R20
	assign pe_exc_o = pe_exc_r; // R16
	assign obj_exc_o = obj_exc_r; // R19
endmodule

// File: tb/rcl_loader_asserts.sv
// Purpose: Port-level timing checks for the config code loader
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every loader instance below the module
`timescale 1ns/1ps
module rcl_loader_asserts
import rcl_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic cfg_valid_i,
	input wire logic cfg_last_i,
	input wire logic cfg_ready_o,
	input wire rcl_pkg::rcl_obj_cfg_t obj_cfg_o,
	input wire logic obj_cfg_valid_o,
	input wire rcl_pkg::rcl_pe_cfg_t pe_cfg_o,
	input wire logic pe_active_o,
	input wire logic code_end_o,
	input wire logic task_end_o,
	input wire logic exec_enable_o,
	input wire logic [1:0] pe_exc_o
);
	// ==========================================================
	// Start window: sticky errors may clear
	logic [1:0] wr_cnt_r;
	logic [1:0] wr_cnt_nxt;
	wire ctrl_wr = hsel_i && htrans_i[1] && hwrite_i
		&& haddr_i[7:0] == RCL_OFF_CTRL;
	assign wr_cnt_nxt = ctrl_wr ? 2'h3
		: (wr_cnt_r != 2'h0 ? wr_cnt_r - 2'h1 : 2'h0);
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			wr_cnt_r <= 2'h0;
		else
			wr_cnt_r <= wr_cnt_nxt;
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_last_taken;
		cfg_valid_i && cfg_ready_o && cfg_last_i;
	endsequence
	sequence s_bad_set;
		obj_cfg_valid_o && (obj_cfg_o.size == 16'h0000
			|| obj_cfg_o.access_time == 16'h0000);
	endsequence

	a_bus_okay:
	assert property (hreadyout_o && !hresp_o)
		else $error("bus answer not zero-wait okay");
	a_exec_after_end:
	assert property (exec_enable_o |-> task_end_o)
		else $error("execution enabled before task end");
	a_exec_no_exc:
	assert property (exec_enable_o |-> pe_exc_o == RCL_EXC_NONE)
		else $error("execution enabled with exception");
	a_done_no_fetch:
	assert property (task_end_o |-> !cfg_ready_o)
		else $error("stream accepted after final code");
	a_err_no_fetch:
	assert property (pe_exc_o != RCL_EXC_NONE |-> !cfg_ready_o)
		else $error("stream accepted after abort");
	a_last_closes:
	assert property (s_last_taken |=> !cfg_ready_o [*2])
		else $error("stream accepted after final byte");
	a_end_after_code:
	assert property ($rose(task_end_o) |-> code_end_o
		|| $past(code_end_o) || $past(code_end_o, 2))
		else $error("task end without code end");
	a_zero_cost_flags:
	assert property (pe_active_o |->
		pe_cfg_o.no_cost == (pe_cfg_o.cost == 16'h0000)
		&& pe_cfg_o.no_time == (pe_cfg_o.time_limit == 16'h0000))
		else $error("cost or time flag wrong");
	a_bad_set_err:
	assert property (s_bad_set |-> ##[0:2] pe_exc_o == RCL_EXC_BADOP)
		else $error("zero size or access time not refused");
	a_exc_sticky:
	assert property (pe_exc_o != RCL_EXC_NONE && wr_cnt_r == 2'h0
		&& !ctrl_wr |=> $stable(pe_exc_o))
		else $error("exception code not held");
endmodule

bind rcl_loader rcl_loader_asserts chk_u (.*);

// File: tb/rcl_src.sv
// Purpose: Byte source standing in for the config code store
// Assumes: Bench pushes {last, byte} words into q
// Notes: Idle data toggles so a stale byte never looks held
`timescale 1ns/1ps
module rcl_src
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic ready_i,
	output logic valid_o,
	output logic [7:0] data_o,
	output logic last_o
);
	logic [8:0] q[$];
	// Offer holds until taken at a rising edge
	always @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			valid_o <= 1'b0;
			data_o <= 8'h00;
			last_o <= 1'b0;
		end
		else if (!valid_o || ready_i)
		begin
			if (q.size() != 0)
			begin
				{last_o, data_o} <= q.pop_front();
				valid_o <= 1'b1;
			end
			else
			begin
				valid_o <= 1'b0;
				data_o <= ~data_o;
				last_o <= 1'b0;
			end
		end
	end
endmodule

// File: tb/rcl_loader_tb.sv
// Purpose: Self-checking bench for the config code loader
// Assumes: Zero-wait bus slave, source model on the stream side
// Notes: Error cases reset mid-run to flush a stalled source
`timescale 1ns/1ps
module rcl_loader_tb;
	import rcl_pkg::*;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic hsel_i = 1'b0, hwrite_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o, v;
	logic hreadyout_o, hresp_o, cfg_valid_i, cfg_last_i, cfg_ready_o;
	logic [7:0] cfg_data_i;
	rcl_obj_cfg_t obj_cfg_o;
	rcl_obj_init_t obj_init_o;
	rcl_sw_conn_t sw_conn_o;
	rcl_pe_cfg_t pe_cfg_o;
	logic obj_cfg_valid_o, obj_init_valid_o, sw_conn_valid_o, pe_active_o;
	logic code_end_o, task_end_o, exec_enable_o;
	logic [1:0] pe_exc_o, obj_exc_o;
	int failures, n_tests, n_cyc, n_obj, n_sw, n_pe, n_end;
	logic [7:0] ib[$];
	bit bq[$];

	rcl_loader dut_u
	(
		.*,
		.hsize_i(3'h2),
		.hready_i(hreadyout_o)
	);
	rcl_src src_u
	(
		.clock_i, .reset_n_i, .ready_i(cfg_ready_o), .valid_o(cfg_valid_i),
		.data_o(cfg_data_i), .last_o(cfg_last_i)
	);

	always #10 clock_i = ~clock_i;

	// ==========================================================
	// Pulse monitor and hang limit
	always @(posedge clock_i)
	begin
		n_obj += obj_cfg_valid_o;
		n_sw += sw_conn_valid_o;
		n_pe += pe_active_o;
		n_end += code_end_o;
		if (obj_init_valid_o === 1'b1)
			ib.push_back(obj_init_o.value);
		n_cyc++;
		if (n_cyc == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock_i);
		hsel_i <= 1'b1;
		haddr_i <= {24'h0, a};
		hwrite_i <= wr;
		htrans_i <= 2'h2;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		v = hrdata_o;
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic do_reset();
		@(posedge clock_i);
		reset_n_i <= 1'b0;
		repeat (16) @(posedge clock_i);
		reset_n_i <= 1'b1;
	endtask

	task automatic put(input logic [31:0] val, input int w);
		for (int i = w - 1; i >= 0; i--)
			bq.push_back(val[i]);
	endtask

	// Pads the tail with zeros; every queued bit is sent
	task automatic send(input bit fin);
		logic [7:0] b;
		while (bq.size() != 0)
		begin
			for (int i = 7; i >= 0; i--)
				b[i] = bq.size() != 0 ? bq.pop_front() : 1'b0;
			src_u.q.push_back({fin && bq.size() == 0, b});
		end
	endtask

	task automatic ctl(input bit last_config_flag, input bit next_offset_present_flag);
		put(last_config_flag, 1);
		put(next_offset_present_flag, 1);
		put(32'h11223344, 32);
		put(32'h55667788, 32);
	endtask

	task automatic obj(input logic [15:0] sz, input logic [15:0] acc,
		input int len, input int nsw);
		put(sz, 16);
		put(acc, 16);
		put(len, 8);
		for (int i = 0; i < len; i++)
			put(8'ha0 + i, 8);
		put(nsw, 6);
		for (int i = 0; i < nsw; i++)
			put({8'h07 + i[7:0], 4'h5}, 12);
	endtask

	task automatic pe(input logic dyn, input logic [15:0] cost,
		input logic [15:0] tm);
		put(16'h0102, 16);
		put(20'habcde, 20);
		put(dyn, 1);
		put(3'h4, 3);
		put(cost, 16);
		put(tm, 16);
		put(8'h1b, 8);
	endtask

	task automatic start_run();
		{n_obj, n_sw, n_pe, n_end} = '0;
		ib.delete();
		bus(1'b1, RCL_OFF_CTRL, 32'h1);
		@(posedge clock_i);
	endtask

	task automatic wait_end();
		for (int k = 0; k < 3000 && task_end_o !== 1'b1
			&& pe_exc_o === 2'h0 && obj_exc_o === 2'h0; k++)
			@(posedge clock_i);
		repeat (4) @(posedge clock_i);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_idle();
		rd(RCL_OFF_STATUS);
		chk("status idle", 32'h0, v);
		rd(8'h40);
		chk("unmapped", 32'h0, v);
		bus(1'b1, 8'h40, 32'hffffffff);
		rd(RCL_OFF_CTRL);
		chk("ctrl read", 32'h0, v);
		chk("ready idle", 32'h0, cfg_ready_o);
	endtask

	task automatic t_full();
		start_run();
		ctl(1'b1, 1'b1);
		put(8'h01, 8);
		obj(16'h0004, 16'h0009, 2, 1);
		put(16'h0001, 16);
		pe(1'b1, 16'h0000, 16'h0005);
		put(32'hcafe0001, 32);
		send(1'b1);
		wait_end();
		chk("obj size", 32'h4, obj_cfg_o.size);
		chk("obj time", 32'h9, obj_cfg_o.access_time);
		chk("obj full", 32'h1, obj_cfg_o.full);
		chk("init n", 32'h2, ib.size());
		chk("init b1", 32'ha1, ib[1]);
		chk("sw conn", 32'h00075, sw_conn_o);
		chk("obj sw n", 32'h2, n_obj + n_sw);
		chk("pe id", 32'h0102, pe_cfg_o.element_identifier);
		chk("pe op", 32'habcde, pe_cfg_o.opcode);
		chk("pe dyn", 32'h1, pe_cfg_o.dynamic);
		chk("pe ports", 32'h4, pe_cfg_o.port_count);
		chk("pe cost", 32'h2, {pe_cfg_o.no_cost, pe_cfg_o.no_time});
		chk("pe time", 32'h5, pe_cfg_o.time_limit);
		chk("pe acc", 32'he4, pe_cfg_o.access[7:0]);
		chk("pe active", 32'h1, n_pe);
		chk("code end", 32'h1, n_end);
		chk("exec", 32'h3, {task_end_o, exec_enable_o});
		rd(RCL_OFF_STATUS);
		chk("status", 32'h10a, v[8:0]);
		rd(RCL_OFF_ID0);
		chk("id0", 32'h11223344, v);
		rd(RCL_OFF_ID1);
		chk("id1", 32'h55667788, v);
		rd(RCL_OFF_NEXT);
		chk("next", 32'hcafe0001, v);
		rd(RCL_OFF_COUNT);
		chk("count", 32'h00010001, v);
	endtask

	task automatic t_two();
		start_run();
		ctl(1'b0, 1'b0);
		put(8'h01, 8);
		obj(16'h0010, 16'h0003, 0, 0);
		put(16'h0000, 16);
		ctl(1'b1, 1'b0);
		put(8'h00, 8);
		put(16'h0000, 16);
		send(1'b1);
		wait_end();
		chk("code ends", 32'h2, n_end);
		chk("empty obj", 32'h0, obj_cfg_o.full + ib.size());
		chk("exec", 32'h1, exec_enable_o);
		rd(RCL_OFF_COUNT);
		chk("count", 32'h00000002, v);
	endtask

	task automatic t_abort();
		start_run();
		ctl(1'b1, 1'b0);
		send(1'b0);
		for (int k = 0; k < 300 && (src_u.q.size() != 0
			|| cfg_valid_i === 1'b1); k++)
			@(posedge clock_i);
		rd(RCL_OFF_STATUS);
		chk("busy", 32'h1, v[0]);
		bus(1'b1, RCL_OFF_CTRL, 32'h2);
		rd(RCL_OFF_STATUS);
		chk("aborted", 32'h0, {v[0], cfg_ready_o});
	endtask

	// Zero size, init longer than object, stream cut mid-field
	task automatic t_error(input int kind);
		start_run();
		ctl(1'b1, 1'b0);
		put(8'h01, 8);
		if (kind == 2)
			put(16'h0004, 16);
		else
			obj(kind == 0 ? 16'h0000 : 16'h0002, 16'h0009, 2 * kind + 1, 0);
		send(1'b1);
		wait_end();
		if (kind == 1)
			chk("obj exc", {30'h0, RCL_DOX_SIZE}, obj_exc_o);
		else
			chk("pe exc", {30'h0, RCL_EXC_BADOP}, pe_exc_o);
		chk("no exec", 32'h0, exec_enable_o);
		rd(RCL_OFF_STATUS);
		chk("error bit", 32'h1, v[2]);
		src_u.q.delete();
		do_reset();
	endtask

	initial
	begin
		do_reset();
		t_idle();
		t_full();
		t_two();
		t_abort();
		for (int k = 0; k < 3; k++)
			t_error(k);
		give_verdict();
	end
endmodule
